// ===== rorf_defines.vh
// Constants for the rail override and fault mask register bank.
// Assumes inclusion by bare name from the design files.
`ifndef RORF_DEFINES_VH
`define RORF_DEFINES_VH

// Register offsets on the register access port
`define RORF_OFF_OVERRIDE_ADDR 8'h9f
`define RORF_ON_ONE_ADDR 8'ha0
`define RORF_ON_TWO_ADDR 8'ha1
`define RORF_FAULT_MASK_ONE_ADDR 8'ha2

// Reset values
`define RORF_OFF_OVERRIDE_RST 8'he0
`define RORF_ON_ONE_RST 8'h80
`define RORF_ON_TWO_RST 8'h89
`define RORF_FAULT_MASK_ONE_RST 8'hc0
`define RORF_UNMAPPED_DATA 8'h00

// Forced-off bit positions in the off-override register
`define RORF_SWITCH_B2_OFF_BIT 7
`define RORF_SWITCH_B1_OFF_BIT 6
`define RORF_SWITCH_A1_OFF_BIT 5
`define RORF_TERM_LDO_OFF_BIT 4
`define RORF_OFF_RSVD_MSB 3

// Fields of the second on-override register
`define RORF_LEVEL_MSB 7
`define RORF_LEVEL_LSB 4
`define RORF_ON_TWO_RAIL_MSB 3
`define RORF_OUT4_IDX 3

// Rail vector layout: [5:0] step-down 1..6, 6 switch A1, 7 LDO A2,
// 8 LDO A3, 9 switch B1, 10 switch B2, 11 termination LDO
`define RORF_RAIL_COUNT 12
`define RORF_FAULT_COUNT 8
`define RORF_NO_OFF_FORCE 1'b1
`define RORF_STEPDOWN_NO_OFF 6'h3f

`endif

// ===== rorf_host.sv
// Host model on the register access port.
// Assumes the bench calls one task at a time.
`timescale 1ns/1ps
`default_nettype none
module rorf_host (
  input wire logic ref_clk,
  input wire logic [7:0] reg_rdata_r,
  input wire logic reg_rvalid_r,
  output logic reg_wr = 1'b0,
  output logic reg_rd = 1'b0,
  output logic [7:0] reg_addr = 8'h00,
  output logic [7:0] reg_wdata = 8'h00
);
  // One write, reserved nibble kept clear
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= (a == 8'h9f) ? {d[7:4], 4'h0} : d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  // One read, data taken after the answer edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata_r;
    v = reg_rvalid_r;
  endtask
endmodule
`default_nettype wire

// ===== rorf_rail_gate.v
// Per-rail enable combiner: forced-off, forced-on and request inputs.
// Assumes all inputs synchronous to ref_clk; output registered.
`timescale 1ns/1ps
`default_nettype none

module rorf_rail_gate #(
  parameter N = 12
) (
  input wire ref_clk,
  input wire rst,
  input wire [N-1:0] off_n,
  input wire [N-1:0] force_on,
  input wire [N-1:0] request,
  output reg [N-1:0] enable_r
);

  wire [N-1:0] enable_nxt;

  // Off bit low wins; else forced on or request
  assign enable_nxt = off_n & (force_on | request);

  // Re-evaluated every clock
  always @(posedge ref_clk)
  begin
    if (rst)
      enable_r <= {N{1'b0}};
    else
      enable_r <= enable_nxt;
  end

endmodule

`default_nettype wire

// ===== rorf_regs.v
// Rail override, output level and fault mask register bank.
// Assumes a serial-bus front end turns host transfers into single-cycle
// register read and write strobes on the access port below.
`timescale 1ns/1ps
`default_nettype none
`include "rorf_defines.vh"

module rorf_regs #(
  parameter RAILS = `RORF_RAIL_COUNT,
  parameter FAULTS = `RORF_FAULT_COUNT
) (
  input wire ref_clk,
  input wire rst,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata_r,
  output reg reg_rvalid_r,
  input wire [RAILS-1:0] rail_request,
  output wire [RAILS-1:0] rail_enable_r,
  input wire [FAULTS-1:0] rail_fault,
  output reg shutdown_r,
  input wire [3:0] gpo_is_gp_out,
  input wire [3:0] gpo_push_pull,
  input wire [3:0] gpo_alt_level,
  output reg [3:0] gpo_out_r,
  output reg [3:0] gpo_oe_r
);

  reg [7:0] rail_off_override_r;
  reg [7:0] rail_on_override_one_r;
  reg [7:0] rail_on_override_two_output_level_r;
  reg [7:0] fault_shutdown_mask_one_r;
  reg [7:0] rdata_nxt;
  reg [3:0] gpo_out_nxt;
  reg [3:0] gpo_oe_nxt;
  reg [3:0] level_ctl;
  integer i;

  wire [RAILS-1:0] off_vec;
  wire [RAILS-1:0] on_vec;
  wire [3:0] out_level;
  wire [3:0] addr_hit;

  // Select bit of each register in the decoded offset, and pin count
  localparam SEL_OFF = 0;
  localparam SEL_ON_ONE = 1;
  localparam SEL_ON_TWO = 2;
  localparam SEL_MASK = 3;
  localparam GPO_PINS = 4;

  // Offset to one-hot register select; unmapped offsets give no select
  function [3:0] decode_offset;
    input [7:0] offset;
    begin
      case (offset)
        `RORF_OFF_OVERRIDE_ADDR: decode_offset = 4'h1;
        `RORF_ON_ONE_ADDR: decode_offset = 4'h2;
        `RORF_ON_TWO_ADDR: decode_offset = 4'h4;
        `RORF_FAULT_MASK_ONE_ADDR: decode_offset = 4'h8;
        default: decode_offset = 4'h0;
      endcase
    end
  endfunction

  // One decode shared by the write and read paths
  assign addr_hit = decode_offset(reg_addr);

  // Register writes at documented offsets; all bits stored as written
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      rail_off_override_r <= `RORF_OFF_OVERRIDE_RST;
      rail_on_override_one_r <= `RORF_ON_ONE_RST;
      rail_on_override_two_output_level_r <= `RORF_ON_TWO_RST;
      fault_shutdown_mask_one_r <= `RORF_FAULT_MASK_ONE_RST;
    end
    else if (reg_wr)
    begin
      // Writes to unmapped offsets select nothing and are dropped
      if (addr_hit[SEL_OFF])
        rail_off_override_r <= reg_wdata;
      if (addr_hit[SEL_ON_ONE])
        rail_on_override_one_r <= reg_wdata;
      if (addr_hit[SEL_ON_TWO])
        rail_on_override_two_output_level_r <= reg_wdata;
      if (addr_hit[SEL_MASK])
        fault_shutdown_mask_one_r <= reg_wdata;
    end
  end

  // Read mux; unmapped offsets read zero
  always @*
  begin
    rdata_nxt = `RORF_UNMAPPED_DATA;
    if (addr_hit[SEL_OFF])
      rdata_nxt = rail_off_override_r;
    if (addr_hit[SEL_ON_ONE])
      rdata_nxt = rail_on_override_one_r;
    if (addr_hit[SEL_ON_TWO])
      rdata_nxt = rail_on_override_two_output_level_r;
    if (addr_hit[SEL_MASK])
      rdata_nxt = fault_shutdown_mask_one_r;
  end

  // Read data registered one cycle after the strobe
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      reg_rdata_r <= `RORF_UNMAPPED_DATA;
      reg_rvalid_r <= 1'b0;
    end
    else
    begin
      reg_rvalid_r <= reg_rd;
      if (reg_rd)
        reg_rdata_r <= rdata_nxt;
    end
  end

  // Forced-off vector; rails with off bits held elsewhere never forced off
  assign off_vec = {
    rail_off_override_r[`RORF_TERM_LDO_OFF_BIT],
    rail_off_override_r[`RORF_SWITCH_B2_OFF_BIT],
    rail_off_override_r[`RORF_SWITCH_B1_OFF_BIT],
    `RORF_NO_OFF_FORCE,
    `RORF_NO_OFF_FORCE,
    rail_off_override_r[`RORF_SWITCH_A1_OFF_BIT],
    `RORF_STEPDOWN_NO_OFF};

  // Forced-on vector from both on-override registers
  assign on_vec = {rail_on_override_two_output_level_r[`RORF_ON_TWO_RAIL_MSB:0],
    rail_on_override_one_r};

  // Rail enable combiner
  rorf_rail_gate #(
    .N(RAILS)
  ) u_gate (
    .ref_clk(ref_clk),
    .rst(rst),
    .off_n(off_vec),
    .force_on(on_vec),
    .request(rail_request),
    .enable_r(rail_enable_r)
  );

  // Shutdown on any unmasked fault
  always @(posedge ref_clk)
  begin
    if (rst)
      shutdown_r <= 1'b0;
    else
      shutdown_r <= |(rail_fault & ~fault_shutdown_mask_one_r);
  end

  // Level bits of the general outputs, pin 1 in the lowest bit
  assign out_level =
    rail_on_override_two_output_level_r[`RORF_LEVEL_MSB:`RORF_LEVEL_LSB];

  // General output pin drive: level control or alternate function
  always @*
  begin
    gpo_out_nxt = 4'h0;
    gpo_oe_nxt = 4'h0;
    level_ctl = gpo_is_gp_out;
    // Out4 takes level control only as open-drain
    level_ctl[`RORF_OUT4_IDX] = gpo_is_gp_out[`RORF_OUT4_IDX] &
      ~gpo_push_pull[`RORF_OUT4_IDX];
    for (i = 0; i < GPO_PINS; i = i + 1)
    begin
      if (level_ctl[i] && gpo_push_pull[i])
      begin
        gpo_out_nxt[i] = out_level[i];
        gpo_oe_nxt[i] = 1'b1;
      end
      else if (level_ctl[i])
      begin
        gpo_out_nxt[i] = 1'b0;
        gpo_oe_nxt[i] = ~out_level[i];
      end
      else
      begin
        gpo_out_nxt[i] = gpo_alt_level[i];
        gpo_oe_nxt[i] = 1'b1;
      end
    end
  end

  // Pin drive registers
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      gpo_out_r <= 4'h0;
      gpo_oe_r <= 4'h0;
    end
    else
    begin
      gpo_out_r <= gpo_out_nxt;
      gpo_oe_r <= gpo_oe_nxt;
    end
  end

endmodule

`default_nettype wire

// ===== rorf_regs_props.sv
// Port checker for the rail override register bank.
// Assumes one clock domain and a bind onto rorf_regs.
`timescale 1ns/1ps
`default_nettype none
module rorf_props (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata_r,
  input wire logic reg_rvalid_r,
  input wire logic [11:0] rail_request,
  input wire logic [11:0] rail_enable_r,
  input wire logic [7:0] rail_fault,
  input wire logic shutdown_r,
  input wire logic [3:0] gpo_is_gp_out,
  input wire logic [3:0] gpo_push_pull,
  input wire logic [3:0] gpo_alt_level,
  input wire logic [3:0] gpo_out_r,
  input wire logic [3:0] gpo_oe_r
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Off write for switch A1, then a quiet cycle
  sequence s_off;
    reg_wr && reg_addr == 8'h9f && !reg_wdata[5] ##1 !reg_wr;
  endsequence
  sequence s_rd;
    reg_rd ##1 reg_rvalid_r;
  endsequence
  property p_rd; reg_rd |-> s_rd; endproperty
  property p_rv; !reg_rd |=> !reg_rvalid_r; endproperty
  property p_um; reg_rd && (reg_addr < 8'h9f || reg_addr > 8'ha2) |=> reg_rdata_r == 8'h00;
  endproperty
  property p_off; s_off |=> !rail_enable_r[6]; endproperty
  property p_step; rail_request[5:0] == 6'h3f |=> rail_enable_r[5:0] == 6'h3f; endproperty
  property p_nf; rail_fault == 8'h00 |=> !shutdown_r; endproperty
  property p_pp; gpo_is_gp_out[0] && gpo_push_pull[0] |=> gpo_oe_r[0]; endproperty
  property p_od; gpo_is_gp_out[1] && !gpo_push_pull[1] |=> !gpo_out_r[1]; endproperty
  property p_o4; gpo_push_pull[3] |=> gpo_oe_r[3] && gpo_out_r[3] == $past(gpo_alt_level[3]);
  endproperty
  a_rd: assert property (p_rd) else $error("read valid late");
  a_rv: assert property (p_rv) else $error("stray read valid");
  a_um: assert property (p_um) else $error("unmapped read data");
  a_off: assert property (p_off) else $error("switch not forced off");
  a_step: assert property (p_step) else $error("step-down not on");
  a_nf: assert property (p_nf) else $error("shutdown without fault");
  a_pp: assert property (p_pp) else $error("push-pull not driving");
  a_od: assert property (p_od) else $error("open-drain drives high");
  a_o4: assert property (p_o4) else $error("out4 push-pull controlled");
endmodule
bind rorf_regs rorf_props rorf_props_inst (.ref_clk, .rst, .reg_wr, .reg_rd, .reg_addr,
  .reg_wdata, .reg_rdata_r, .reg_rvalid_r, .rail_request, .rail_enable_r, .rail_fault,
  .shutdown_r, .gpo_is_gp_out, .gpo_push_pull, .gpo_alt_level, .gpo_out_r, .gpo_oe_r);
`default_nettype wire

// ===== tb.sv
// Self-checking bench for the rail override register bank.
// Assumes rorf_regs driven by the rorf_host model.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr, reg_rd, reg_rvalid_r, shutdown_r, ok;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_r, d;
  logic [7:0] rail_fault = 8'h00;
  logic [11:0] rail_request = 12'h000;
  logic [11:0] rail_enable_r;
  logic [3:0] is_gp = 4'h0, pp = 4'h0, alt = 4'h0, gpo_out_r, gpo_oe_r;
  logic [7:0] sh [4];
  int bad_count = 0;
  int check_count = 0;
  rorf_regs rorf_regs_inst (.ref_clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata_r, .reg_rvalid_r, .rail_request, .rail_enable_r, .rail_fault, .shutdown_r,
    .gpo_is_gp_out(is_gp), .gpo_push_pull(pp), .gpo_alt_level(alt), .gpo_out_r, .gpo_oe_r);
  rorf_host rorf_host_inst (.ref_clk, .reg_rdata_r, .reg_rvalid_r, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata);
  initial forever #2.5 ref_clk = ~ref_clk;
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Expected enables from shadow registers
  function automatic logic [11:0] en_exp(input logic [11:0] rq);
    logic [11:0] off;
    off = {sh[0][4], sh[0][7], sh[0][6], 2'b11, sh[0][5], 6'h3f};
    return off & ({sh[2][3:0], sh[1]} | rq);
  endfunction
  // Expected pins as {out, oe}
  function automatic logic [7:0] gpo_exp();
    logic [3:0] o, e;
    logic lc;
    for (int i = 0; i < 4; i++)
    begin
      lc = is_gp[i] && (i < 3 || !pp[i]);
      o[i] = lc ? pp[i] & sh[2][4+i] : alt[i];
      e[i] = !lc | pp[i] | !sh[2][4+i];
    end
    return {o, e};
  endfunction
  // Load all four registers, read back, apply inputs, check outputs
  task automatic step(input logic [31:0] v, input logic [11:0] rq, input logic [7:0] f);
    for (int k = 0; k < 4; k++)
    begin
      sh[k] = k ? v[8*k +: 8] : {v[7:4], 4'h0};
      rorf_host_inst.wr(8'(8'h9f + k), v[8*k +: 8]);
    end
    for (int k = 0; k < 4; k++)
    begin
      rorf_host_inst.rd(8'(8'h9f + k), d, ok);
      chk({ok, d}, {1'b1, sh[k]});
    end
    @(posedge ref_clk);
    rail_request <= rq;
    rail_fault <= f;
    is_gp <= 4'($urandom);
    pp <= 4'($urandom);
    alt <= 4'($urandom);
    repeat (2) @(posedge ref_clk);
    #1;
    chk(rail_enable_r, en_exp(rail_request));
    chk(shutdown_r, |(rail_fault & ~sh[3]));
    chk({gpo_out_r, gpo_oe_r}, gpo_exp());
  endtask
  initial
  begin
    #400000;
    bad_count++;
    final_report();
  end
  initial
  begin
    void'($urandom(32'hae65));
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    rorf_host_inst.wr(8'ha3, 8'hff);
    rorf_host_inst.rd(8'h9f, d, ok);
    chk({ok, d}, 9'h1e0);
    rorf_host_inst.rd(8'ha0, d, ok);
    chk({ok, d}, 9'h180);
    rorf_host_inst.rd(8'ha1, d, ok);
    chk({ok, d}, 9'h189);
    rorf_host_inst.rd(8'ha2, d, ok);
    chk({ok, d}, 9'h1c0);
    rorf_host_inst.rd(8'ha3, d, ok);
    chk({ok, d}, 9'h100);
    $display("reset test done");
    step(32'h00ffff00, 12'hfff, 8'hff);
    step(32'hff0000f0, 12'h000, 8'hff);
    $display("corner test done");
    repeat (40) step($urandom, 12'($urandom), 8'($urandom));
    $display("random test done");
    final_report();
  end
endmodule
`default_nettype wire
